// [logic/wit_map.svh]
`ifndef WIT_MAP_SVH
`define WIT_MAP_SVH

// ****************************************
// bus addresses
// ****************************************
// write port shared by counter and control, split by key
`define WIT_ADDR_CTRL_WR    16'hffa4
`define WIT_ADDR_RST_WR     16'hffa6
// read addresses, one byte each
`define WIT_ADDR_CTRL_RD    16'hffa4
`define WIT_ADDR_CNT_RD     16'hffa5
`define WIT_ADDR_RST_RD     16'hffa7

// ****************************************
// write keys in the upper byte
// ****************************************
`define WIT_KEY_CNT         8'h5a
`define WIT_KEY_CTRL        8'ha5

// ****************************************
// timer_control_status fields
// ****************************************
`define WIT_TCS_OVF_BIT     7
`define WIT_TCS_MODE_BIT    6
`define WIT_TCS_EN_BIT      5
`define WIT_TCS_RSV_ONES    2'b11
`define WIT_TCS_RESET       8'h18

// ****************************************
// reset_control_status fields
// ****************************************
`define WIT_RCS_WATCHDOG_OVERFLOW_FLAG_BIT    7
`define WIT_RCS_RESET_ON_OVERFLOW_ENABLE_BIT    6
`define WIT_RCS_RSV_ONES    5'h1f
`define WIT_RCS_RESET       8'h1f

// ****************************************
// counter and timing
// ****************************************
`define WIT_CNT_MAX         8'hff
`define WIT_CNT_ZERO        8'h00
`define WIT_RST_PULSE_CYC   519
`define WIT_UNMAPPED_RDATA  8'h00

`endif

// [logic/wit_pkg.sv]
package wit_pkg;

  // clock divider select code
  typedef logic [2:0] wit_div_sel_t;

  // tick counter value
  typedef logic [7:0] wit_count_t;

  // internal reset generator states, gray along idle -> hold
  typedef enum logic [1:0]
  {
    WIT_RS_IDLE = 2'b00,
    WIT_RS_HOLD = 2'b01
  } wit_rst_state_e;

endpackage

// [logic/wit_prescaler.sv]
`include "wit_map.svh"

module wit_prescaler
  import wit_pkg::*;
#(
  parameter int DIV_W = 17
)
(
  // clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  // control
  input  wire logic              run_i,
  input  wit_pkg::wit_div_sel_t  sel_i,
  // increment pulse
  output logic                   tick_o
);

  // ****************************************
  // divider
  // ****************************************

  logic [DIV_W-1:0] div_reg;
  logic [DIV_W-1:0] div_next;
  logic             tick_reg;
  logic             tick_next;

  // mask of low bits that must all be one for the selected ratio
  function automatic logic [DIV_W-1:0] div_mask(input wit_div_sel_t sel);
    logic [DIV_W-1:0] m;
    m = '0;
    case (sel)
      3'h0:    m = DIV_W'(17'h00001);
      3'h1:    m = DIV_W'(17'h0003f);
      3'h2:    m = DIV_W'(17'h0007f);
      3'h3:    m = DIV_W'(17'h001ff);
      3'h4:    m = DIV_W'(17'h007ff);
      3'h5:    m = DIV_W'(17'h01fff);
      3'h6:    m = DIV_W'(17'h07fff);
      3'h7:    m = DIV_W'(17'h1ffff);
      default: m = '0;
    endcase
    return m;
  endfunction

  // held at zero while stopped so the first period is always full
  always_comb
  begin
    div_next  = run_i ? div_reg + DIV_W'(1) : '0;
    tick_next = run_i && ((div_reg & div_mask(sel_i)) == div_mask(sel_i));
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end
    else
    begin
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign tick_o = tick_reg;

endmodule

// [logic/wit_reset_gen.sv]
`include "wit_map.svh"

module wit_reset_gen
  import wit_pkg::*;
#(
  parameter int PULSE_CYC = `WIT_RST_PULSE_CYC
)
(
  // clock and reset (external pin only)
  input  wire logic clk_i,
  input  wire logic rst_i,
  // request and pulse
  input  wire logic start_i,
  output logic      active_o
);

  // ****************************************
  // pulse stretcher
  // ****************************************

  wit_rst_state_e state_reg;
  wit_rst_state_e state_next;
  logic [9:0]     cnt_reg;
  logic [9:0]     cnt_next;

  // count down the pulse length once started
  always_comb
  begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      WIT_RS_IDLE:
      begin
        if (start_i)
        begin
          state_next = WIT_RS_HOLD;
          cnt_next   = 10'(PULSE_CYC - 1);
        end
      end
      WIT_RS_HOLD:
      begin
        if (cnt_reg == 10'h000)
          state_next = WIT_RS_IDLE;
        else
          cnt_next = cnt_reg - 10'h001;
      end
      default:
      begin
        state_next = WIT_RS_IDLE;
        cnt_next   = 10'h000;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state_reg <= WIT_RS_IDLE;
      cnt_reg   <= 10'h000;
    end
    else
    begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign active_o = (state_reg == WIT_RS_HOLD);

endmodule

// [logic/wit_top.sv]
`include "wit_map.svh"

// Contract
// - interval mode wrap sets interval overflow flag
// - overflow flag clears by read-one then write-zero
// - internal watchdog reset clears interval overflow flag
// - mode bit: 0 interval, 1 watchdog
// - watchdog overflow with enable resets device
// - enable starts counting; clearing zeroes counter
// - reserved bits read as one, read-only
// - divider select picks eight peripheral clock ratios
// - reset control loads 1f, survives internal reset
// - watchdog flag set only on watchdog wrap
// - watchdog flag clears by read-one then write-zero
// - no device reset: counter, control still reset
// - reset control bit five reads zero
// - eight-bit up-counter, readable and writable
// - keyed word writes only; byte writes ignored
// - internal reset pulse lasts 519 clocks
// - counter write beats simultaneous increment
module wit_top
  import wit_pkg::*;
#(
  parameter int RST_PULSE_CYC = `WIT_RST_PULSE_CYC
)
(
  // clock and external reset pin
  input  wire logic        CLK_SYS_I,
  input  wire logic        SYS_RST_I,
  // processor register bus
  input  wire logic [15:0] BUS_ADDR_I,
  input  wire logic        BUS_RD_I,
  input  wire logic        BUS_WR_I,
  input  wire logic        BUS_WORD_I,
  input  wire logic [15:0] BUS_WDATA_I,
  output logic      [7:0]  BUS_RDATA_O,
  output logic             BUS_RVALID_O,
  // events
  output logic             INTERVAL_OVERFLOW_IRQ_O,
  output logic             INTERNAL_RESET_O
);

  // ****************************************
  // declarations
  // ****************************************

  // timer_control_status fields
  logic          interval_overflow_flag_reg;
  logic          interval_overflow_flag_next;
  logic          mode_select_reg;
  logic          mode_select_next;
  logic          count_enable_reg;
  logic          count_enable_next;
  wit_div_sel_t  clock_divider_select_reg;
  wit_div_sel_t  clock_divider_select_next;
  logic          ovf_armed_reg;
  logic          ovf_armed_next;

  // tick counter
  wit_count_t    tick_counter_reg;
  wit_count_t    tick_counter_next;

  // reset_control_status fields
  logic          watchdog_overflow_flag_reg;
  logic          watchdog_overflow_flag_next;
  logic          reset_on_overflow_enable_reg;
  logic          reset_on_overflow_enable_next;
  logic          watchdog_overflow_flag_armed_reg;
  logic          watchdog_overflow_flag_armed_next;

  // read port
  logic [7:0]    rdata_reg;
  logic [7:0]    rdata_next;
  logic          rvalid_reg;
  logic          rvalid_next;

  // decoded accesses
  logic          wr_cnt;
  logic          wr_ctrl;
  logic          wr_reset_on_overflow_enable;
  logic          wr_watchdog_overflow_flag_clr;
  logic          rd_ctrl;
  logic          rd_rst;

  // counter events
  logic          tick;
  logic          overflow;
  logic          wd_overflow;
  logic          iv_overflow;
  logic          timer_reset;
  logic          internal_reset;

  // ****************************************
  // helper functions
  // ****************************************

  // word write to one address carrying the given key; all bus terms passed in
  function automatic logic keyed_write(input logic wr, input logic word,
                                       input logic [7:0] key_in, input logic [15:0] addr,
                                       input logic [15:0] match, input logic [7:0] key);
    return wr && word && (addr == match) && (key_in == key);
  endfunction

  // timer_control_status as software sees it
  function automatic logic [7:0] ctrl_view(input logic ovf, input logic mode,
                                           input logic en, input wit_div_sel_t cks);
    return {ovf, mode, en, `WIT_TCS_RSV_ONES, cks};
  endfunction

  // reset_control_status as software sees it
  function automatic logic [7:0] rst_view(input logic watchdog_overflow_flag, input logic reset_on_overflow_enable);
    return {watchdog_overflow_flag, reset_on_overflow_enable, 1'b0, `WIT_RCS_RSV_ONES};
  endfunction

  // ****************************************
  // bus decode
  // ****************************************

  // byte writes fail the word check and are dropped silently
  assign wr_cnt      = keyed_write(BUS_WR_I, BUS_WORD_I, BUS_WDATA_I[15:8], BUS_ADDR_I,
                                   `WIT_ADDR_CTRL_WR, `WIT_KEY_CNT);
  assign wr_ctrl     = keyed_write(BUS_WR_I, BUS_WORD_I, BUS_WDATA_I[15:8], BUS_ADDR_I,
                                   `WIT_ADDR_CTRL_WR, `WIT_KEY_CTRL);
  assign wr_reset_on_overflow_enable     = keyed_write(BUS_WR_I, BUS_WORD_I, BUS_WDATA_I[15:8], BUS_ADDR_I,
                                   `WIT_ADDR_RST_WR, `WIT_KEY_CNT);
  assign wr_watchdog_overflow_flag_clr = keyed_write(BUS_WR_I, BUS_WORD_I, BUS_WDATA_I[15:8], BUS_ADDR_I,
                                   `WIT_ADDR_RST_WR, `WIT_KEY_CTRL)
                       && (BUS_WDATA_I[7:0] == 8'h00);
  assign rd_ctrl     = BUS_RD_I && (BUS_ADDR_I == `WIT_ADDR_CTRL_RD);
  assign rd_rst      = BUS_RD_I && (BUS_ADDR_I == `WIT_ADDR_RST_RD);

  // ****************************************
  // submodules
  // ****************************************

  // divider restarts from zero whenever counting stops
  wit_prescaler #(
    .DIV_W (17)
  ) u_prescaler (
    .clk_i  (CLK_SYS_I),
    .rst_i  (SYS_RST_I || timer_reset),
    .run_i  (count_enable_reg),
    .sel_i  (clock_divider_select_reg),
    .tick_o (tick)
  );

  // only the external pin may cut a running internal reset short
  wit_reset_gen #(
    .PULSE_CYC (RST_PULSE_CYC)
  ) u_reset_gen (
    .clk_i    (CLK_SYS_I),
    .rst_i    (SYS_RST_I),
    .start_i  (wd_overflow && reset_on_overflow_enable_reg),
    .active_o (internal_reset)
  );

  // ****************************************
  // overflow detection
  // ****************************************

  // a tick landing on a counter write is lost, so no wrap then
  assign overflow    = tick && count_enable_reg && !wr_cnt
                       && (tick_counter_reg == `WIT_CNT_MAX);
  assign wd_overflow = overflow && mode_select_reg;
  assign iv_overflow = overflow && !mode_select_reg;
  // watchdog wrap resets counter and control with or without device reset
  assign timer_reset = wd_overflow || internal_reset;

  // ****************************************
  // tick counter
  // ****************************************

  // write wins over increment; disable forces zero
  always_comb
  begin
    tick_counter_next = tick_counter_reg;
    if (!count_enable_reg)
      tick_counter_next = `WIT_CNT_ZERO;
    if (wr_cnt)
      tick_counter_next = BUS_WDATA_I[7:0];
    else if (tick && count_enable_reg)
      tick_counter_next = tick_counter_reg + 8'h01;
    if (timer_reset)
      tick_counter_next = `WIT_CNT_ZERO;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      tick_counter_reg <= `WIT_CNT_ZERO;
    else
      tick_counter_reg <= tick_counter_next;
  end

  // ****************************************
  // timer_control_status
  // ****************************************

  // flag clear needs a prior read seeing it set; a new wrap beats the clear
  always_comb
  begin
    mode_select_next            = mode_select_reg;
    count_enable_next           = count_enable_reg;
    clock_divider_select_next   = clock_divider_select_reg;
    interval_overflow_flag_next = interval_overflow_flag_reg;
    ovf_armed_next              = ovf_armed_reg;
    if (rd_ctrl && interval_overflow_flag_reg)
      ovf_armed_next = 1'b1;
    if (wr_ctrl)
    begin
      mode_select_next          = BUS_WDATA_I[`WIT_TCS_MODE_BIT];
      count_enable_next         = BUS_WDATA_I[`WIT_TCS_EN_BIT];
      clock_divider_select_next = BUS_WDATA_I[2:0];
      // writing one leaves the flag alone
      if (!BUS_WDATA_I[`WIT_TCS_OVF_BIT] && ovf_armed_reg)
      begin
        interval_overflow_flag_next = 1'b0;
        ovf_armed_next              = 1'b0;
      end
    end
    if (iv_overflow)
      interval_overflow_flag_next = 1'b1;
    if (timer_reset)
    begin
      mode_select_next            = 1'b0;
      count_enable_next           = 1'b0;
      clock_divider_select_next   = 3'h0;
      interval_overflow_flag_next = 1'b0;
      ovf_armed_next              = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      interval_overflow_flag_reg <= 1'(`WIT_TCS_RESET >> `WIT_TCS_OVF_BIT);
      mode_select_reg            <= 1'b0;
      count_enable_reg           <= 1'b0;
      clock_divider_select_reg   <= 3'h0;
      ovf_armed_reg              <= 1'b0;
    end
    else
    begin
      interval_overflow_flag_reg <= interval_overflow_flag_next;
      mode_select_reg            <= mode_select_next;
      count_enable_reg           <= count_enable_next;
      clock_divider_select_reg   <= clock_divider_select_next;
      ovf_armed_reg              <= ovf_armed_next;
    end
  end

  // ****************************************
  // reset_control_status
  // ****************************************

  // kept through the internal reset; only the pin restores it
  always_comb
  begin
    watchdog_overflow_flag_next   = watchdog_overflow_flag_reg;
    reset_on_overflow_enable_next = reset_on_overflow_enable_reg;
    watchdog_overflow_flag_armed_next               = watchdog_overflow_flag_armed_reg;
    if (rd_rst && watchdog_overflow_flag_reg)
      watchdog_overflow_flag_armed_next = 1'b1;
    if (wr_reset_on_overflow_enable)
      reset_on_overflow_enable_next = BUS_WDATA_I[`WIT_RCS_RESET_ON_OVERFLOW_ENABLE_BIT];
    if (wr_watchdog_overflow_flag_clr && watchdog_overflow_flag_armed_reg)
    begin
      watchdog_overflow_flag_next = 1'b0;
      watchdog_overflow_flag_armed_next             = 1'b0;
    end
    if (wd_overflow)
      watchdog_overflow_flag_next = 1'b1;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      watchdog_overflow_flag_reg   <= 1'b0;
      reset_on_overflow_enable_reg <= 1'b0;
      watchdog_overflow_flag_armed_reg               <= 1'b0;
    end
    else
    begin
      watchdog_overflow_flag_reg   <= watchdog_overflow_flag_next;
      reset_on_overflow_enable_reg <= reset_on_overflow_enable_next;
      watchdog_overflow_flag_armed_reg               <= watchdog_overflow_flag_armed_next;
    end
  end

  // ****************************************
  // read port
  // ****************************************

  // one-cycle registered answer; unmapped addresses return zero
  always_comb
  begin
    rvalid_next = BUS_RD_I;
    rdata_next  = rdata_reg;
    if (BUS_RD_I)
    begin
      case (BUS_ADDR_I)
        `WIT_ADDR_CTRL_RD:
          rdata_next = ctrl_view(interval_overflow_flag_reg, mode_select_reg,
                                 count_enable_reg, clock_divider_select_reg);
        `WIT_ADDR_CNT_RD:
          rdata_next = tick_counter_reg;
        `WIT_ADDR_RST_RD:
          rdata_next = rst_view(watchdog_overflow_flag_reg, reset_on_overflow_enable_reg);
        default:
          rdata_next = `WIT_UNMAPPED_RDATA;
      endcase
    end
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
    begin
      rdata_reg  <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // ****************************************
  // outputs
  // ****************************************

  assign BUS_RDATA_O             = rdata_reg;
  assign BUS_RVALID_O            = rvalid_reg;
  // level request, follows the flag; software re-reads after clearing
  assign INTERVAL_OVERFLOW_IRQ_O = interval_overflow_flag_reg;
  assign INTERNAL_RESET_O        = internal_reset;

endmodule

// [testbench/wit_top_checker.sv]
module wit_top_checker
#(
  parameter int RST_PULSE_CYC = 519
)
(
  // clock and reset
  input wire logic        CLK_SYS_I,
  input wire logic        SYS_RST_I,
  // bus
  input wire logic [15:0] BUS_ADDR_I,
  input wire logic        BUS_RD_I,
  input wire logic [7:0]  BUS_RDATA_O,
  input wire logic        BUS_RVALID_O,
  // events
  input wire logic        INTERVAL_OVERFLOW_IRQ_O,
  input wire logic        INTERNAL_RESET_O
);
  // ****************************************
  // pulse length counter
  // ****************************************
  int pulse_reg;
  int pulse_next;

  // counts high cycles, because a long pulse cannot be unrolled
  always_comb
  begin
    pulse_next = INTERNAL_RESET_O ? pulse_reg + 1 : 0;
  end

  always_ff @(posedge CLK_SYS_I)
  begin
    if (SYS_RST_I)
      pulse_reg <= 0;
    else
      pulse_reg <= pulse_next;
  end

  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge CLK_SYS_I); endclocking
  default disable iff (SYS_RST_I);

  rd_answer_a: assert property (BUS_RD_I |=> BUS_RVALID_O)
    else $error("read got no answer");
  answer_cause_a: assert property (BUS_RVALID_O |-> $past(BUS_RD_I))
    else $error("answer without read");
  ctrl_ones_a: assert property (BUS_RD_I && BUS_ADDR_I == 16'hffa4 |=> BUS_RDATA_O[4:3] == 2'b11)
    else $error("control reserved bits wrong");
  rst_ones_a: assert property (BUS_RD_I && BUS_ADDR_I == 16'hffa7 |=> BUS_RDATA_O[5:0] == 6'h1f)
    else $error("reset control reserved bits wrong");
  ovf_read_a: assert property (BUS_RD_I && BUS_ADDR_I == 16'hffa4 |=> BUS_RDATA_O[7] == $past(INTERVAL_OVERFLOW_IRQ_O))
    else $error("overflow flag read differs from irq");
  pulse_len_a: assert property ($fell(INTERNAL_RESET_O) |-> pulse_reg == RST_PULSE_CYC)
    else $error("reset pulse length wrong");
  pulse_max_a: assert property (INTERNAL_RESET_O |-> pulse_reg < RST_PULSE_CYC)
    else $error("reset pulse too long");
  reset_clears_ovf_a: assert property (INTERNAL_RESET_O |=> !INTERVAL_OVERFLOW_IRQ_O)
    else $error("overflow flag kept in internal reset");
  ctrl_held_a: assert property (INTERNAL_RESET_O && BUS_RD_I && BUS_ADDR_I == 16'hffa4 |=> BUS_RDATA_O == 8'h18)
    else $error("control not held in internal reset");
endmodule

bind wit_top wit_top_checker #(.RST_PULSE_CYC(RST_PULSE_CYC)) i_wit_top_checker (
  .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .BUS_ADDR_I(BUS_ADDR_I),
  .BUS_RD_I(BUS_RD_I), .BUS_RDATA_O(BUS_RDATA_O), .BUS_RVALID_O(BUS_RVALID_O),
  .INTERVAL_OVERFLOW_IRQ_O(INTERVAL_OVERFLOW_IRQ_O), .INTERNAL_RESET_O(INTERNAL_RESET_O));

// [testbench/wit_top_tb.sv]
module wit_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // short pulse keeps the run brief
  localparam int PW = 8;
  logic        CLK_SYS_I = 1'b0;
  logic        SYS_RST_I = 1'b1;
  logic [15:0] BUS_ADDR_I = 16'h0000;
  logic        BUS_RD_I = 1'b0;
  logic        BUS_WR_I = 1'b0;
  logic        BUS_WORD_I = 1'b0;
  logic [15:0] BUS_WDATA_I = 16'h0000;
  logic [7:0]  BUS_RDATA_O;
  logic        BUS_RVALID_O;
  logic        INTERVAL_OVERFLOW_IRQ_O;
  logic        INTERNAL_RESET_O;
  int          bad_count = 0;
  int          n_checks = 0;
  int          cyc = 0;

  always #5 CLK_SYS_I = ~CLK_SYS_I;

  wit_top #(.RST_PULSE_CYC(PW)) i_wit_top (
    .CLK_SYS_I(CLK_SYS_I), .SYS_RST_I(SYS_RST_I), .BUS_ADDR_I(BUS_ADDR_I),
    .BUS_RD_I(BUS_RD_I), .BUS_WR_I(BUS_WR_I), .BUS_WORD_I(BUS_WORD_I),
    .BUS_WDATA_I(BUS_WDATA_I), .BUS_RDATA_O(BUS_RDATA_O), .BUS_RVALID_O(BUS_RVALID_O),
    .INTERVAL_OVERFLOW_IRQ_O(INTERVAL_OVERFLOW_IRQ_O), .INTERNAL_RESET_O(INTERNAL_RESET_O));

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] s, input logic [15:0] x);
    n_checks++;
    if (s !== x)
    begin
      $display("unexpected at %0t: seen %h expected %h", $time, s, x);
      bad_count++;
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] v, input logic w);
    @(posedge CLK_SYS_I);
    BUS_WR_I <= 1'b1;
    BUS_WORD_I <= w;
    BUS_ADDR_I <= a;
    BUS_WDATA_I <= v;
    @(posedge CLK_SYS_I);
    BUS_WR_I <= 1'b0;
  endtask

  // sampled at the falling edge, where the one-cycle answer is settled
  task automatic rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge CLK_SYS_I);
    BUS_RD_I <= 1'b1;
    BUS_ADDR_I <= a;
    @(posedge CLK_SYS_I);
    BUS_RD_I <= 1'b0;
    @(negedge CLK_SYS_I);
    chk(BUS_RVALID_O, 1'b1);
    d = BUS_RDATA_O;
  endtask

  task automatic rc(input logic [15:0] a, input logic [7:0] x);
    logic [7:0] d;
    rd(a, d);
    chk(d, x);
  endtask

  task automatic wait_irq();
    int n;
    n = 0;
    while (INTERVAL_OVERFLOW_IRQ_O !== 1'b1 && n < 50)
    begin
      @(negedge CLK_SYS_I);
      n++;
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    rc(16'hffa4, 8'h18);
    rc(16'hffa5, 8'h00);
    rc(16'hffa7, 8'h1f);
    rc(16'hffa0, 8'h00);
    $display("test reset done");
  endtask

  // slowest divider so no tick disturbs the stored count
  task automatic t_keys();
    wr(16'hffa4, 16'ha527, 1'b1);
    wr(16'hffa4, 16'h5a37, 1'b1);
    rc(16'hffa5, 8'h37);
    wr(16'hffa4, 16'h5a55, 1'b0);
    wr(16'hffa4, 16'h5b55, 1'b1);
    wr(16'hffa4, 16'ha500, 1'b0);
    rc(16'hffa5, 8'h37);
    rc(16'hffa4, 8'h3f);
    wr(16'hffa4, 16'ha5df, 1'b1);
    rc(16'hffa4, 8'h5f);
    rc(16'hffa5, 8'h00);
    wr(16'hffa4, 16'ha500, 1'b1);
    $display("test keys done");
  endtask

  // two reads a whole number of periods apart see the same phase
  task automatic t_div();
    int dvt[7] = '{2, 64, 128, 512, 2048, 8192, 32768};
    int dd;
    logic [7:0] a;
    logic [7:0] b;
    for (int s = 0; s < 7; s++)
    begin
      dd = (s == 0) ? 16 : dvt[s];
      wr(16'hffa4, {8'ha5, 5'b00100, 3'(s)}, 1'b1);
      rd(16'hffa5, a);
      repeat (dd - 2) @(posedge CLK_SYS_I);
      rd(16'hffa5, b);
      chk(16'(b - a), 16'(dd / dvt[s]));
      wr(16'hffa4, 16'ha500, 1'b1);
    end
    $display("test divider done");
  endtask

  // counter write lands on the first tick, so the write must win
  task automatic t_interval();
    wr(16'hffa4, 16'ha520, 1'b1);
    @(posedge CLK_SYS_I);
    wr(16'hffa4, 16'h5afe, 1'b1);
    rc(16'hffa5, 8'hfe);
    wait_irq();
    chk(INTERVAL_OVERFLOW_IRQ_O, 1'b1);
    wr(16'hffa4, 16'ha520, 1'b1);
    @(negedge CLK_SYS_I);
    chk(INTERVAL_OVERFLOW_IRQ_O, 1'b1);
    rc(16'hffa7, 8'h1f);
    rc(16'hffa4, 8'hb8);
    wr(16'hffa4, 16'ha520, 1'b1);
    rc(16'hffa4, 8'h38);
    wr(16'hffa4, 16'ha500, 1'b1);
    $display("test interval done");
  endtask

  task automatic t_wdog_quiet();
    logic seen;
    seen = 1'b0;
    wr(16'hffa4, 16'ha560, 1'b1);
    wr(16'hffa4, 16'h5afe, 1'b1);
    repeat (30)
    begin
      @(negedge CLK_SYS_I);
      seen = seen | INTERNAL_RESET_O;
    end
    chk(seen, 1'b0);
    chk(INTERVAL_OVERFLOW_IRQ_O, 1'b0);
    wr(16'hffa6, 16'ha500, 1'b1);
    rc(16'hffa7, 8'h9f);
    rc(16'hffa4, 8'h18);
    rc(16'hffa5, 8'h00);
    wr(16'hffa6, 16'ha500, 1'b1);
    rc(16'hffa7, 8'h1f);
    $display("test watchdog quiet done");
  endtask

  // interval flag left set on purpose, so the internal reset must clear it
  task automatic t_wdog_reset();
    int n;
    wr(16'hffa4, 16'ha520, 1'b1);
    wr(16'hffa4, 16'h5afe, 1'b1);
    wait_irq();
    wr(16'hffa4, 16'ha560, 1'b1);
    wr(16'hffa6, 16'h5a40, 1'b1);
    wr(16'hffa4, 16'h5afe, 1'b1);
    n = 0;
    while (INTERNAL_RESET_O !== 1'b1 && n < 600)
    begin
      @(negedge CLK_SYS_I);
      n++;
    end
    chk(INTERNAL_RESET_O, 1'b1);
    rc(16'hffa4, 8'h18);
    n = 3;
    while (INTERNAL_RESET_O === 1'b1 && n < 600)
    begin
      @(negedge CLK_SYS_I);
      if (INTERNAL_RESET_O === 1'b1)
        n++;
    end
    chk(16'(n), 16'(PW));
    chk(INTERVAL_OVERFLOW_IRQ_O, 1'b0);
    rc(16'hffa7, 8'hdf);
    @(posedge CLK_SYS_I);
    SYS_RST_I <= 1'b1;
    @(posedge CLK_SYS_I);
    SYS_RST_I <= 1'b0;
    rc(16'hffa7, 8'h1f);
    $display("test watchdog reset done");
  endtask

  // ****************************************
  // run control
  // ****************************************
  // the divider sweep dominates, about 44000 cycles
  always @(posedge CLK_SYS_I)
  begin
    cyc++;
    if (cyc == 70000)
    begin
      bad_count++;
      final_report();
    end
  end

  initial
  begin
    repeat (20) @(posedge CLK_SYS_I);
    SYS_RST_I <= 1'b0;
    t_reset();
    t_keys();
    t_interval();
    t_wdog_quiet();
    t_wdog_reset();
    t_div();
    final_report();
  end
endmodule
